// file: rtl/exil_defines.svh
`ifndef EXIL_DEFINES_SVH
`define EXIL_DEFINES_SVH

// ----------------------------------------
// Widths, reset values and sense codes
// ----------------------------------------
`define EXIL_PORTA_W      4
`define EXIL_SYNC_RST     1'b1
`define EXIL_LATCH_RST    1'b0
`define EXIL_SENS_EDGE    1'b0
`define EXIL_SENS_LEVEL   1'b1

`endif

// file: rtl/exil_pkg.sv
package exil_pkg;
   // One-hot sequencing of the interrupt entry
   typedef enum logic [2:0] {
      EXIL_IDLE  = 3'b001,
      EXIL_ENTER = 3'b010,
      EXIL_VECT  = 3'b100
   } exil_state_t;

   typedef enum logic [1:0] {
      EXIL_SRC_NONE = 2'b00,
      EXIL_SRC_TRAP = 2'b01,
      EXIL_SRC_EXT  = 2'b10
   } exil_src_t;
endpackage : exil_pkg

// file: rtl/exil_sync_if.sv
`timescale 1ns/1ps
interface exil_sync_if;
   logic pin_level;   // Filtered level, valid when agreed
   logic pin_fall;    // One-cycle pulse on agreed falling change
   modport src  (output pin_level, output pin_fall);
   modport sink (input  pin_level, input  pin_fall);
endinterface : exil_sync_if

// file: rtl/exil_pin_sync.sv
`timescale 1ns/1ps
`include "exil_defines.svh"
module exil_pin_sync (
   input  wire logic     clk,     // System clock
   input  wire logic     rst_n,   // Async reset, active low
   input  wire logic     pin_in,  // Raw asynchronous pin
   exil_sync_if.src      sync     // Filtered level and fall pulse
);
   import exil_pkg::*;

   logic s1_r;
   logic s2_r;
   logic s3_r;

   // ----------------------------------------
   // Three-stage synchroniser
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_r <= `EXIL_SYNC_RST;
         s2_r <= `EXIL_SYNC_RST;
         s3_r <= `EXIL_SYNC_RST;
      end else begin
         s1_r <= pin_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // Level moves only when stages two and three agree
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync.pin_level <= `EXIL_SYNC_RST;
         sync.pin_fall  <= 1'b0;
      end else begin
         sync.pin_fall <= 1'b0;
         if (s2_r == s3_r) begin
            sync.pin_level <= s3_r;
            sync.pin_fall  <= sync.pin_level & ~s3_r;
         end
      end
   end
endmodule : exil_pin_sync

// file: rtl/exil_latch.sv
`timescale 1ns/1ps
`include "exil_defines.svh"
// Operation
// - The soft trap instruction raises an interrupt that no mask or enable can block.
// - External requests come from the request pin and the four port A request pins.
// - External requests are blocked while the CPU mask flag is set or the enable bit is clear.
// - At instruction end the latch is tested first, mask and enable only when it is set.
// - External entry starts only with latch set, mask flag clear and enable bit set.
// - The latch is cleared during the external entry's vector fetch so a new request can be caught.
// - A request caught in service is taken once return from interrupt clears the mask.
// - An option bit picks falling-edge-only or falling-edge-plus-low sensitivity.
// - In edge-plus-level mode a fall or a held low sets the latch.
// - In edge-plus-level mode the request stays while any wired-OR source holds the pin low.
// - In edge-only mode only a request pin fall or a port A rise sets the latch.
// - In edge-only mode a new request needs the pin to rise and fall again.
// - With port A requests enabled, any high port A pin hides the request pin until all low.
module exil_latch (
   input  wire logic                     clk,              // 100 MHz clock
   input  wire logic                     rst_n,            // Async reset, active low
   input  wire logic                     ext_request_pin_n,// Request pin, active low
   input  wire logic [`EXIL_PORTA_W-1:0] port_a_request_pins, // Port A request pins
   input  wire logic                     port_a_irq_en,    // Port A request enable
   input  wire logic                     level_sense_opt,  // Option: 1 edge+level
   input  wire logic                     external_enable_bit, // External enable
   input  wire logic                     cpu_mask_flag,    // CPU global mask
   input  wire logic                     insn_done,        // Instruction boundary pulse
   input  wire logic                     soft_trap_instruction, // Trap executing
   input  wire logic                     vector_fetch,     // Vector fetch pulse
   output exil_pkg::exil_src_t           int_start_src,    // Source of entry started
   output logic                          int_start,        // Entry start pulse
   output logic                          ext_latch,        // Request latch state
   output logic                          ext_pending       // Latch and gates open
);
   import exil_pkg::*;

   exil_sync_if                  pin_if ();
   exil_sync_if                  pa_if [`EXIL_PORTA_W] ();
   logic [`EXIL_PORTA_W-1:0]     pa_lvl;
   logic                         level_opt_r;
   logic                         pa_block;
   logic                         req_set;
   logic                         ext_ok;
   exil_state_t                  state_r;

   // ----------------------------------------
   // Pin conditioning
   // ----------------------------------------
   exil_pin_sync u_irq_sync (
      .clk    (clk),
      .rst_n  (rst_n),
      .pin_in (ext_request_pin_n),
      .sync   (pin_if.src)
   );

   genvar gi;
   generate
      for (gi = 0; gi < `EXIL_PORTA_W; gi++) begin : g_pa
         exil_pin_sync u_pa_sync (
            .clk    (clk),
            .rst_n  (rst_n),
            .pin_in (port_a_request_pins[gi]),
            .sync   (pa_if[gi].src)
         );
         assign pa_lvl[gi] = pa_if[gi].pin_level;
      end
   endgenerate

   // Option strap caught after reset release, not under reset
   logic opt_taken_r;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         level_opt_r <= `EXIL_SENS_EDGE;
         opt_taken_r <= 1'b0;
      end else if (!opt_taken_r) begin
         level_opt_r <= level_sense_opt;
         opt_taken_r <= 1'b1;
      end
   end

   // Port A high forces the request pin to look idle; also a port A
   // rising level is itself a request source
   assign pa_block = port_a_irq_en && (|pa_lvl);

   // Resets high: port A syncs leave reset at 1, so a low start
   // would read their settling as a rising request
   logic pa_any_r;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) pa_any_r <= 1'b1;
      else        pa_any_r <= pa_block;
   end

   always_comb begin
      req_set = 1'b0;
      if (!pa_block) begin
         if (pin_if.pin_fall)
            req_set = 1'b1;
         if (level_opt_r == `EXIL_SENS_LEVEL && !pin_if.pin_level)
            req_set = 1'b1;
      end
      if (pa_block && !pa_any_r)
         req_set = 1'b1;
   end

   // ----------------------------------------
   // Request latch
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         ext_latch <= `EXIL_LATCH_RST;
      else if (req_set)
         ext_latch <= 1'b1;       // Set beats the fetch clear
      else if (vector_fetch && state_r == EXIL_VECT)
         ext_latch <= 1'b0;
   end

   assign ext_ok = ext_latch && !cpu_mask_flag && external_enable_bit;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) ext_pending <= 1'b0;
      else        ext_pending <= ext_ok;
   end

   // ----------------------------------------
   // Entry sequencing
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r       <= EXIL_IDLE;
         int_start     <= 1'b0;
         int_start_src <= EXIL_SRC_NONE;
      end else begin
         int_start <= 1'b0;
         case (state_r)
            EXIL_IDLE: begin
               if (soft_trap_instruction) begin
                  int_start     <= 1'b1;
                  int_start_src <= EXIL_SRC_TRAP;
                  state_r       <= EXIL_ENTER;
               end else if (insn_done && ext_latch) begin
                  if (ext_ok) begin
                     int_start     <= 1'b1;
                     int_start_src <= EXIL_SRC_EXT;
                     state_r       <= EXIL_VECT;
                  end
               end
            end
            EXIL_ENTER: begin
               if (vector_fetch) state_r <= EXIL_IDLE;
            end
            EXIL_VECT: begin
               if (vector_fetch) state_r <= EXIL_IDLE;
            end
            default: state_r <= EXIL_IDLE;
         endcase
      end
   end
endmodule : exil_latch

// file: verification/exil_latch_props.sv
`timescale 1ns/1ps
`include "exil_defines.svh"
module exil_latch_chk (
   input wire logic                     clk,                   // Clock
   input wire logic                     rst_n,                 // Reset
   input wire logic                     ext_request_pin_n,     // Pin
   input wire logic [`EXIL_PORTA_W-1:0] port_a_request_pins,   // Port A
   input wire logic                     port_a_irq_en,         // PA enable
   input wire logic                     level_sense_opt,       // Option
   input wire logic                     external_enable_bit,   // Enable
   input wire logic                     cpu_mask_flag,         // Mask
   input wire logic                     insn_done,             // Boundary
   input wire logic                     soft_trap_instruction, // Trap
   input wire logic                     vector_fetch,          // Vector
   input wire exil_pkg::exil_src_t      int_start_src,         // Source
   input wire logic                     int_start,             // Start
   input wire logic                     ext_latch,             // Latch
   input wire logic                     ext_pending            // Pending
);
   import exil_pkg::*;
   logic [3:0] quiet_r;
   // Saturating count of pin-idle cycles; covers the sync depth
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n) quiet_r <= 4'h0;
      else if (!ext_request_pin_n || |port_a_request_pins) quiet_r <= 4'h0;
      else if (quiet_r != 4'hf) quiet_r <= quiet_r + 4'h1;
   logic ext_busy_r;
   // External entry open from its start pulse until its vector fetch
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n) ext_busy_r <= 1'b0;
      else if (int_start && int_start_src == EXIL_SRC_EXT) ext_busy_r <= 1'b1;
      else if (vector_fetch) ext_busy_r <= 1'b0;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_trap_cause: assert property (int_start && int_start_src == EXIL_SRC_TRAP
      |-> $past(soft_trap_instruction)) else $error("trap start without trap");
   a_ext_gate: assert property (int_start && int_start_src == EXIL_SRC_EXT
      |-> $past(insn_done) && $past(ext_latch) && !$past(cpu_mask_flag)
      && $past(external_enable_bit))
      else $error("external start with gate closed");
   a_pend_track: assert property (ext_pending ==
      ($past(ext_latch) && !$past(cpu_mask_flag) && $past(external_enable_bit)))
      else $error("pending");
   a_mask_block: assert property (insn_done && cpu_mask_flag && !soft_trap_instruction
      |=> !int_start) else $error("start while masked");
   a_start_once: assert property (int_start |=> !int_start) else $error("long start");
   a_latch_keep: assert property (ext_latch && !vector_fetch |=> ext_latch)
      else $error("latch lost");
   a_quiet_idle: assert property (quiet_r >= 4'h8 && !ext_latch |=> !ext_latch)
      else $error("latch set on idle pin");
   a_vect_clear: assert property (vector_fetch && quiet_r >= 4'h8
      && (ext_busy_r || (int_start && int_start_src == EXIL_SRC_EXT)) |=> !ext_latch)
      else $error("latch not cleared");
   c_trap: cover property (int_start && int_start_src == EXIL_SRC_TRAP);
   c_ext: cover property (int_start && int_start_src == EXIL_SRC_EXT);
   c_clear: cover property ($fell(ext_latch));
endmodule : exil_latch_chk
bind exil_latch exil_latch_chk u_chk (.clk, .rst_n, .ext_request_pin_n, .port_a_request_pins,
   .port_a_irq_en, .level_sense_opt, .external_enable_bit, .cpu_mask_flag, .insn_done,
   .soft_trap_instruction, .vector_fetch, .int_start_src, .int_start, .ext_latch, .ext_pending);

// file: verification/exil_src_model.sv
`timescale 1ns/1ps
module exil_src_model (
   input  wire logic [1:0] src_low,  // Sources pulling low
   input  wire logic [3:0] pa_drive, // Port A levels
   output logic            pin_n,    // Wired-OR pin
   output logic [3:0]      pa_pins   // Port A pins
);
   // Pull-up wins once every source lets go
   assign pin_n   = ~|src_low;
   assign pa_pins = pa_drive;
endmodule : exil_src_model

// file: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import exil_pkg::*;
   logic       clk = 1'h0, rst_n = 1'h0, pa_en = 1'h0, lvl = 1'h0, en = 1'h0, mask = 1'h1;
   logic       done = 1'h0, trap = 1'h0, vf = 1'h0, pin_n, start, latch, pend;
   logic [1:0] src_low = 2'h0;
   logic [3:0] pa_drive = 4'h0, pa;
   exil_src_t  src;
   int         failures = 0, total_checks = 0, cyc = 0;
   exil_src_model u_src (.src_low, .pa_drive, .pin_n, .pa_pins(pa));
   exil_latch u_dut (.clk, .rst_n, .ext_request_pin_n(pin_n), .port_a_request_pins(pa),
      .port_a_irq_en(pa_en), .level_sense_opt(lvl), .external_enable_bit(en),
      .cpu_mask_flag(mask), .insn_done(done), .soft_trap_instruction(trap),
      .vector_fetch(vf), .int_start_src(src), .int_start(start), .ext_latch(latch),
      .ext_pending(pend));
   initial forever #5 clk = ~clk;
   task automatic step(input int n = 1);
      repeat (n) @(negedge clk);
   endtask : step
   task automatic chk(input logic [1:0] got, input logic [1:0] exp, input string msg);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t %s", $time, msg);
      end
   endtask : chk
   task automatic results;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : results
   task automatic do_reset(input logic opt);
      rst_n = 1'h0;
      lvl = opt;
      step(5);
      rst_n = 1'h1;
      step(4);
   endtask : do_reset
   task automatic enter(input logic [1:0] exp, input logic go = 1'h1);
      done = 1'h1;
      step();
      done = 1'h0;
      chk(start, {1'h0, go}, "start");
      chk(src, exp, "source");
      vf = 1'h1;
      step();
      vf = 1'h0;
   endtask : enter
   task automatic t_edge;
      en = 1'h1;
      src_low = 2'h1;
      step(8);
      chk(latch, 2'h1, "fall missed");
      enter(EXIL_SRC_TRAP, 1'h0);
      mask = 1'h0;
      step(2);
      chk(pend, 2'h1, "pending");
      enter(EXIL_SRC_EXT);
      step(8);
      chk(latch, 2'h0, "relatched on held low");
      mask = 1'h1;
      src_low = 2'h0;
      step(4);
      src_low = 2'h2;
      step(8);
      chk(latch, 2'h1, "second fall missed");
      mask = 1'h0;
      enter(EXIL_SRC_EXT);
      src_low = 2'h0;
      $display("test edge done");
   endtask : t_edge
   task automatic t_porta;
      pa_en = 1'h1;
      pa_drive = 4'h8;
      step(8);
      enter(EXIL_SRC_EXT);
      src_low = 2'h1;
      step(8);
      chk(latch, 2'h0, "pin seen under port A");
      pa_drive = 4'h0;
      step(8);
      chk(latch, 2'h0, "stale pin after port A");
      src_low = 2'h0;
      step(4);
      src_low = 2'h1;
      step(8);
      chk(latch, 2'h1, "pin lost after port A");
      $display("test port a done");
   endtask : t_porta
   task automatic t_level;
      pa_en = 1'h0;
      pa_drive = 4'h0;
      src_low = 2'h3;
      do_reset(1'h1);
      step(2);
      enter(EXIL_SRC_EXT);
      step(4);
      chk(latch, 2'h1, "low not relatched");
      src_low = 2'h1;
      enter(EXIL_SRC_EXT);
      step(4);
      chk(latch, 2'h1, "wired-OR lost");
      src_low = 2'h0;
      step(8);
      enter(EXIL_SRC_EXT);
      step(8);
      chk(latch, 2'h0, "released pin relatched");
      $display("test level done");
   endtask : t_level
   task automatic t_trap;
      trap = 1'h1;
      step();
      trap = 1'h0;
      chk(start, 2'h1, "trap ignored");
      chk(src, EXIL_SRC_TRAP, "trap source");
      vf = 1'h1;
      step();
      vf = 1'h0;
      $display("test trap done");
   endtask : t_trap
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         failures++;
         results();
      end
   end
   initial begin
      do_reset(1'h0);
      chk(latch, 2'h0, "latch after reset");
      t_trap();
      t_edge();
      t_porta();
      t_level();
      results();
   end
endmodule : tb_top
